// ==== rtl/battery_measurement_scheduler.v ====
/*
 * measurement scheduler of a multi-cell battery monitor: cell and
 * temperature result capture, charge integrator modes, pack sum and an
 * avalon-mm register slave. assumes converter codes arrive on pins and
 * are stable around each rising edge of the converter strobe.
 */
// What this block does
// - cell, thermistor, die codes are 14-bit unsigned
// - converter enable set on entering normal state
// - cell trips run only with converter enabled
// - five-cell groups, 50 ms windows, 250 ms frame
// - higher groups measured in parallel with lowest
// - balancing group uses 12.5 ms windows
// - gain and offset trims readable by host
// - 16-bit charge integrator, 250 ms period
// - counter enable: reading every 250 ms, alert
// - single count: one conversion, ready flag
// - charge result is 16-bit two's complement
// - source bit 1: thermistors into three results
// - source bit 0: die readings into results
// - source change may take two seconds
// - pack result is cell sum divided by four
// - cells every 250 ms, temperatures every 2 s
// - high and low halves read atomically
`timescale 1ns/1ps
`include "meas_sched_consts.vh"
module battery_measurement_scheduler #(
  parameter [31:0] TICK_CYCLES = `TICK_CYCLES,
  parameter [4:0]  GAIN_TRIM   = `GAIN_TRIM_DEF,
  parameter [7:0]  OFFSET_TRIM = `OFFSET_TRIM_DEF
) (
  input  wire        clk,
  input  wire        reset,
  input  wire        ce,
  input  wire [6:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  output reg  [31:0] readdata,
  output reg         waitrequest,
  input  wire        convStrobe,
  input  wire        normalState,
  input  wire [13:0] cellCodeOne,
  input  wire [13:0] cellCodeTwo,
  input  wire [13:0] cellCodeThree,
  input  wire [15:0] chargeCode,
  input  wire [13:0] tempCodeOne,
  input  wire [13:0] tempCodeTwo,
  input  wire [13:0] tempCodeThree,
  output reg  [2:0]  cellSelectOne,
  output reg  [2:0]  cellSelectTwo,
  output reg  [2:0]  cellSelectThree,
  output reg         tempSourceSel,
  output reg         protectionsActive,
  output reg         alert
);

  // ==========================================================
  // index arithmetic
  // ==========================================================
  // flat cell index of a slot in a group
  function [3:0] cellIndex;
    input [1:0] group;
    input [2:0] slot;
    begin
      // slot has already stepped past the cell whose window closed
      cellIndex = 4'(group * `GROUP_CELLS +
                  (slot == 3'h0 ? `LAST_SLOT : slot - 3'h1));
    end
  endfunction

  // ==========================================================
  // input synchronisers
  // ==========================================================
  localparam SW = 2 + 3 * `CELL_BITS + `CHARGE_BITS + 3 * `CELL_BITS;
  wire [SW-1:0] syncBus;        // synchronised pin bundle
  wire          strobeSync;     // converter strobe, core domain
  wire          normalSync;     // normal state level, core domain
  wire [13:0]   cellSync [0:2]; // synchronised cell codes
  wire [13:0]   tempSync [0:2]; // synchronised temperature codes
  wire [15:0]   chargeSync;     // synchronised charge code

  pin_sync #(.W(SW)) inputSync (
    .clk     (clk),
    .reset   (reset),
    .ce      (ce),
    .asyncIn ({convStrobe, normalState, cellCodeOne, cellCodeTwo,
               cellCodeThree, chargeCode, tempCodeOne, tempCodeTwo,
               tempCodeThree}),
    .syncOut (syncBus)
  );

  assign {strobeSync, normalSync, cellSync[0], cellSync[1],
          cellSync[2], chargeSync, tempSync[0], tempSync[1],
          tempSync[2]} = syncBus;

  // ==========================================================
  // state
  // ==========================================================
  reg         strobeLast;          // strobe one cycle ago
  reg         normalLast;          // normal level one cycle ago
  reg [13:0]  cellLatch [0:2];     // latest converter code per group
  reg [13:0]  tempLatch [0:2];     // latest temperature codes
  reg [15:0]  chargeLatch;         // latest integrator code
  reg [13:0]  cellResult [0:14];   // held cell results
  reg [13:0]  tempResult [0:2];    // held temperature results
  reg [15:0]  chargeResult;        // held charge result
  reg [15:0]  packResult;          // held pack sum
  reg         adcEnable;           // converter enable bit
  reg         counterEnable;       // continuous counting bit
  reg         singleBusy;          // single count in progress
  reg [14:0]  balance;             // three groups of balance bits
  reg [31:0]  prescale;            // cycles toward the next tick
  reg         tick;                // one pulse per 12.5 ms
  reg [4:0]   frameCount;          // ticks within a frame
  reg         frameStart;          // one pulse per 250 ms
  reg [2:0]   tempFrames;          // frames since last temperatures
  reg [4:0]   chargeTicks;         // ticks within a charge period
  reg [17:0]  cellSum;             // combinational cell total
  wire        strobeRise;          // converter sample point
  wire        ctlWrite;            // control register written
  wire        staWrite;            // status register written
  wire        chargeDone;          // charge period completes
  wire        counting;            // integrator is running
  wire [2:0]  slot [0:2];          // current slot per group
  wire [2:0]  windowDone;          // window end per group
  integer     i;

  assign strobeRise = strobeSync & ~strobeLast;
  assign ctlWrite   = write & ~waitrequest & (address == `ADDR_CONTROL);
  assign staWrite   = write & ~waitrequest & (address == `ADDR_STATUS);
  assign counting   = counterEnable | singleBusy;
  assign chargeDone = counting & tick &
                      (chargeTicks == 5'(`FRAME_TICKS - 1));

  // ==========================================================
  // group sequencers, all three run side by side
  // ==========================================================
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : groupSeq
      group_sequencer seq (
        .clk        (clk),
        .reset      (reset),
        .ce         (ce),
        .tick       (tick),
        .frameStart (frameStart),
        .fast       (|balance[g*5 +: 5]),
        .slot       (slot[g]),
        .windowDone (windowDone[g])
      );
    end
  endgenerate

  // ==========================================================
  // timebase: tick, frame and temperature interval
  // ==========================================================
  always @(posedge clk) begin
    if (reset) begin
      prescale   <= 32'h0;
      tick       <= 1'b0;
      frameCount <= 5'h0;
      frameStart <= 1'b0;
      tempFrames <= 3'h0;
    end else if (ce) begin
      tick       <= 1'b0;
      frameStart <= 1'b0;
      if (prescale == TICK_CYCLES - 32'h1) begin
        prescale <= 32'h0;
        tick     <= 1'b1;
        // frame boundary every twenty ticks
        if (frameCount == 5'(`FRAME_TICKS - 1)) begin
          frameCount <= 5'h0;
          frameStart <= 1'b1;
          tempFrames <= tempFrames + 3'h1;
        end else begin
          frameCount <= frameCount + 5'h1;
        end
      end else begin
        prescale <= prescale + 32'h1;
      end
    end
  end

  // ==========================================================
  // converter sampling at strobe edges
  // ==========================================================
  always @(posedge clk) begin
    if (reset) begin
      strobeLast  <= 1'b0;
      normalLast  <= 1'b0;
      chargeLatch <= 16'h0;
      for (i = 0; i < 3; i = i + 1) begin
        cellLatch[i] <= 14'h0;
        tempLatch[i] <= 14'h0;
      end
    end else if (ce) begin
      strobeLast <= strobeSync;
      normalLast <= normalSync;
      if (strobeRise) begin
        chargeLatch <= chargeSync;
        for (i = 0; i < 3; i = i + 1) begin
          cellLatch[i] <= cellSync[i];
          tempLatch[i] <= tempSync[i];
        end
      end
    end
  end

  // ==========================================================
  // pack sum of all cell results
  // ==========================================================
  always @* begin
    cellSum = 18'h0;
    for (i = 0; i < `CELL_COUNT; i = i + 1) begin
      cellSum = cellSum + {4'h0, cellResult[i]};
    end
  end

  // ==========================================================
  // result registers, written only at conversion ends
  // ==========================================================
  always @(posedge clk) begin
    if (reset) begin
      packResult <= 16'h0;
      for (i = 0; i < `CELL_COUNT; i = i + 1) begin
        cellResult[i] <= 14'h0;
      end
      for (i = 0; i < 3; i = i + 1) begin
        tempResult[i] <= 14'h0;
      end
    end else if (ce) begin
      // each group stores the cell whose window just closed
      if (windowDone[0]) begin
        cellResult[cellIndex(2'h0, slot[0])] <= cellLatch[0];
      end
      if (windowDone[1]) begin
        cellResult[cellIndex(2'h1, slot[1])] <= cellLatch[1];
      end
      if (windowDone[2]) begin
        cellResult[cellIndex(2'h2, slot[2])] <= cellLatch[2];
      end
      if (frameStart) begin
        packResult <= cellSum[17:`PACK_SHIFT];
      end
      // temperatures follow the source chosen by tempSourceSel
      if (frameStart && tempFrames == 3'(`TEMP_FRAMES - 1)) begin
        for (i = 0; i < 3; i = i + 1) begin
          tempResult[i] <= tempLatch[i];
        end
      end
    end
  end

  // ==========================================================
  // charge integrator modes and ready flag
  // ==========================================================
  always @(posedge clk) begin
    if (reset) begin
      chargeTicks  <= 5'h0;
      chargeResult <= 16'h0;
      singleBusy   <= 1'b0;
      alert        <= 1'b0;
    end else if (ce) begin
      if (!counting) begin
        chargeTicks <= 5'h0;
      end else if (tick) begin
        chargeTicks <= chargeDone ? 5'h0 : chargeTicks + 5'h1;
      end
      if (chargeDone) begin
        chargeResult <= chargeLatch;
        if (!counterEnable) begin
          singleBusy <= 1'b0;
        end
      end else if (ctlWrite && writedata[`CTL_SINGLE] &&
                   !writedata[`CTL_COUNT_EN]) begin
        singleBusy <= 1'b1;
      end
      // completion wins over a same-cycle clear
      if (chargeDone) begin
        alert <= 1'b1;
      end else if (staWrite && writedata[`STA_READY]) begin
        alert <= 1'b0;
      end
    end
  end

  // ==========================================================
  // control bits and status outputs
  // ==========================================================
  always @(posedge clk) begin
    if (reset) begin
      adcEnable         <= 1'b0;
      counterEnable     <= 1'b0;
      tempSourceSel     <= 1'b0;
      balance           <= 15'h0;
      protectionsActive <= 1'b0;
      cellSelectOne     <= 3'h0;
      cellSelectTwo     <= 3'h0;
      cellSelectThree   <= 3'h0;
    end else if (ce) begin
      if (normalSync && !normalLast) begin
        adcEnable <= 1'b1;
      end else if (ctlWrite) begin
        adcEnable <= writedata[`CTL_ADC_EN];
      end
      if (ctlWrite) begin
        counterEnable <= writedata[`CTL_COUNT_EN];
        tempSourceSel <= writedata[`CTL_TEMP_SEL];
      end
      if (write && !waitrequest && address == `ADDR_BALANCE) begin
        balance <= writedata[14:0];
      end
      protectionsActive <= adcEnable & normalSync;
      cellSelectOne     <= slot[0];
      cellSelectTwo     <= slot[1];
      cellSelectThree   <= slot[2];
    end
  end

  // ==========================================================
  // avalon-mm slave: one wait cycle, whole words read at once
  // ==========================================================
  always @(posedge clk) begin
    if (reset) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0;
    end else if (ce) begin
      waitrequest <= ~((read | write) & waitrequest);
      if ((read | write) && waitrequest) begin
        readdata <= 32'h0;
        case (address)
          `ADDR_CONTROL: begin
            readdata[`CTL_ADC_EN]   <= adcEnable;
            readdata[`CTL_TEMP_SEL] <= tempSourceSel;
            readdata[`CTL_COUNT_EN] <= counterEnable;
            readdata[`CTL_SINGLE]   <= singleBusy;
          end
          `ADDR_STATUS: begin
            readdata[`STA_READY]   <= alert;
            readdata[`STA_NORMAL]  <= normalSync;
            readdata[`STA_PROTECT] <= protectionsActive;
          end
          `ADDR_BALANCE: readdata[14:0] <= balance;
          `ADDR_TRIM: begin
            readdata[4:0] <= GAIN_TRIM;
            readdata[`TRIM_OFFSET_LSB +: 8] <= OFFSET_TRIM;
          end
          `ADDR_CHARGE: readdata[15:0] <= chargeResult;
          `ADDR_PACK:   readdata[15:0] <= packResult;
          `ADDR_TEMP1:  readdata[13:0] <= tempResult[0];
          `ADDR_TEMP2:  readdata[13:0] <= tempResult[1];
          `ADDR_TEMP3:  readdata[13:0] <= tempResult[2];
          default: begin
            // cell words from the base, unmapped reads give zero
            if (address >= `ADDR_CELL_BASE &&
                address[6:2] < 5'(16 + `CELL_COUNT) &&
                address[1:0] == 2'h0) begin
              readdata[13:0] <= cellResult[address[5:2]];
            end
          end
        endcase
      end
    end
  end

endmodule

// ==== rtl/meas_sched_consts.vh ====
/*
 * named constants of the measurement scheduler: register offsets, field
 * positions, reset values and the schedule times with their tick counts.
 * assumes a 200 MHz core clock and a 32-bit avalon-mm register port.
 */
`ifndef MEAS_SCHED_CONSTS_VH
`define MEAS_SCHED_CONSTS_VH

// ==========================================================
// timing
// ==========================================================
`define CLK_PERIOD_NS   5
`define DECIM_SLOW_US   50000
`define DECIM_FAST_US   12500
`define FRAME_US        250000
`define TEMP_US         2000000
`define TICK_US         `DECIM_FAST_US
`define SLOW_TICKS      (`DECIM_SLOW_US / `TICK_US)
`define FAST_TICKS      (`DECIM_FAST_US / `TICK_US)
`define FRAME_TICKS     (`FRAME_US / `TICK_US)
`define TEMP_FRAMES     (`TEMP_US / `FRAME_US)
`define TICK_CYCLES     (`TICK_US * 1000 / `CLK_PERIOD_NS)

// ==========================================================
// sizes
// ==========================================================
`define CELL_BITS       14
`define CHARGE_BITS     16
`define PACK_BITS       16
`define GROUP_CELLS     5
`define CELL_COUNT      15
`define LAST_SLOT       3'h4
`define PACK_SHIFT      2

// ==========================================================
// register byte addresses
// ==========================================================
`define ADDR_CONTROL    7'h00
`define ADDR_STATUS     7'h04
`define ADDR_BALANCE    7'h08
`define ADDR_TRIM       7'h0c
`define ADDR_CHARGE     7'h10
`define ADDR_PACK       7'h14
`define ADDR_TEMP1      7'h18
`define ADDR_TEMP2      7'h1c
`define ADDR_TEMP3      7'h20
`define ADDR_CELL_BASE  7'h40

// ==========================================================
// fields
// ==========================================================
`define CTL_ADC_EN      0
`define CTL_TEMP_SEL    1
`define CTL_COUNT_EN    2
`define CTL_SINGLE      3
`define STA_READY       0
`define STA_NORMAL      1
`define STA_PROTECT     2
`define TRIM_OFFSET_LSB 8

// ==========================================================
// factory trim defaults
// ==========================================================
`define GAIN_TRIM_DEF   5'h0f
`define OFFSET_TRIM_DEF 8'h1e

`endif

// ==== rtl/pin_sync.v ====
/*
 * two flip-flop synchroniser for a bundle of inputs from outside the
 * core clock domain. assumes multi-bit data is stable around the edges
 * of the sampling strobe that later qualifies it.
 */
`timescale 1ns/1ps
module pin_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         reset,
  input  wire         ce,
  input  wire [W-1:0] asyncIn,
  output reg  [W-1:0] syncOut
);

  reg [W-1:0] stageOne;  // metastable stage, read only by syncOut

  // ==========================================================
  // two-stage capture
  // ==========================================================
  // both stages freeze with the clock enable
  always @(posedge clk) begin
    if (reset) begin
      stageOne <= {W{1'b0}};
      syncOut  <= {W{1'b0}};
    end else if (ce) begin
      stageOne <= asyncIn;
      syncOut  <= stageOne;
    end
  end

endmodule

// ==== rtl/group_sequencer.v ====
/*
 * decimation sequencer for one group of five cells. walks the five
 * cells once per frame, each window long or short by balancing.
 * assumes a tick every 12.5 ms and a one-cycle frame start pulse.
 */
`timescale 1ns/1ps
`include "meas_sched_consts.vh"
module group_sequencer (
  input  wire       clk,
  input  wire       reset,
  input  wire       ce,
  input  wire       tick,
  input  wire       frameStart,
  input  wire       fast,
  output reg  [2:0] slot,
  output reg        windowDone
);

  reg       active;     // windows still pending in this frame
  reg [2:0] tickCount;  // ticks spent in the current window
  wire [2:0] limit;     // window length in ticks

  // short window while any cell of the group balances
  assign limit = fast ? 3'(`FAST_TICKS) : 3'(`SLOW_TICKS);

  // ==========================================================
  // window walk
  // ==========================================================
  // windowDone pulses one cycle at the end of each cell window
  always @(posedge clk) begin
    if (reset) begin
      active     <= 1'b0;
      slot       <= 3'h0;
      tickCount  <= 3'h0;
      windowDone <= 1'b0;
    end else if (ce) begin
      // a window may close on the tick that also starts the next frame
      windowDone <= active && tick && (tickCount + 3'h1 >= limit);
      if (frameStart) begin
        // a new frame restarts the walk at the first cell
        active    <= 1'b1;
        slot      <= 3'h0;
        tickCount <= 3'h0;
      end else if (active && tick) begin
        if (tickCount + 3'h1 >= limit) begin
          tickCount  <= 3'h0;
          if (slot == `LAST_SLOT) begin
            active <= 1'b0;
            slot   <= 3'h0;
          end else begin
            slot <= slot + 3'h1;
          end
        end else begin
          tickCount <= tickCount + 3'h1;
        end
      end
    end
  end

endmodule

// ==== tb/battery_measurement_scheduler_properties.sv ====
/* checker: bus handshake, alert level, cell walk, temp source, readdata.
   assumes binding onto the scheduler top, ce held high. */
`timescale 1ns/1ps
module battery_measurement_scheduler_properties (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        normalState,
  input wire logic [2:0]  cellSelectOne,
  input wire logic        tempSourceSel,
  input wire logic        protectionsActive,
  input wire logic        alert
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ==========
  // register bus
  a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered in one cycle");
  a_bus_pulse: assert property (!waitrequest |=> waitrequest)
    else $error("answer longer than one cycle");
  a_bus_cause: assert property ($fell(waitrequest) |-> $past(read || write))
    else $error("answer without request");
  a_read_hold: assert property (!read && !write |=> $stable(readdata))
    else $error("readdata moved while idle");
  // ==========
  // measurement
  a_prot_off: assert property (!normalState [*5] |=> !protectionsActive)
    else $error("protections active outside normal state");
  a_prot_on: assert property ($rose(normalState) |-> ##[1:8] protectionsActive)
    else $error("converter not enabled on normal entry");
  a_alert_hold: assert property (alert && !write && !$past(write) |=> alert)
    else $error("alert dropped without a clear");
  a_sel_step: assert property ($changed(cellSelectOne) |->
    (cellSelectOne == $past(cellSelectOne) + 3'h1 || cellSelectOne == 3'h0)
    && cellSelectOne <= 3'h4) else $error("cell slot walk broken");
  a_temp_hold: assert property ($changed(tempSourceSel) |-> $past(write) || $past(write, 2))
    else $error("temp source changed without write");
endmodule

// ==== tb/converter_model.sv ====
/* model of the converter front: strobe and codes per selected cell.
   assumes the bench supplies the base code and the charge value. */
`timescale 1ns/1ps
module converter_model (
  input  wire logic [2:0]  cellSelectOne,
  input  wire logic [2:0]  cellSelectTwo,
  input  wire logic [2:0]  cellSelectThree,
  input  wire logic        tempSourceSel,
  input  wire logic [13:0] base,
  input  wire logic [15:0] charge,
  output logic             convStrobe,
  output logic [13:0]      cellCodeOne,
  output logic [13:0]      cellCodeTwo,
  output logic [13:0]      cellCodeThree,
  output logic [15:0]      chargeCode,
  output logic [13:0]      tempCodeOne,
  output logic [13:0]      tempCodeTwo,
  output logic [13:0]      tempCodeThree
);
  logic [13:0] tOff; // thermistor or die offset
  // ==========
  // free running strobe, phase unrelated to clk
  initial begin
    convStrobe = 1'b0;
    #7;
    forever #24 convStrobe = ~convStrobe;
  end
  // codes: group g slot s gives base + 64g + s
  assign cellCodeOne   = base + {11'h000, cellSelectOne};
  assign cellCodeTwo   = base + 14'h0040 + {11'h000, cellSelectTwo};
  assign cellCodeThree = base + 14'h0080 + {11'h000, cellSelectThree};
  assign chargeCode    = charge;
  assign tOff          = tempSourceSel ? 14'h0200 : 14'h0300;
  assign tempCodeOne   = base + tOff;
  assign tempCodeTwo   = base + tOff + 14'h0001;
  assign tempCodeThree = base + tOff + 14'h0002;
endmodule

// ==== tb/battery_measurement_scheduler_tb_top.sv ====
/* bench of the measurement scheduler: avalon tasks note expected reads,
   a monitor compares them. assumes ce tied high, 20-cycle tick. */
`timescale 1ns/1ps
`include "meas_sched_consts.vh"
module battery_measurement_scheduler_tb_top;
  localparam int TICK = 20;
  localparam int FRAME = 20 * TICK;
  logic        clk, reset, read, write, waitrequest, convStrobe;
  logic        normalState, tempSourceSel, protectionsActive, alert;
  logic [6:0]  address;
  logic [31:0] writedata, readdata;
  logic [13:0] c1, c2, c3, t1, t2, t3, base;
  logic [15:0] chargeCode, chg;
  logic [2:0]  s1, s2, s3;
  logic [31:0] expVal[$];
  logic [6:0]  expAdr[$];
  int          fails = 0, checks = 0, cyc = 0, n, t0;
  battery_measurement_scheduler #(.TICK_CYCLES(32'd20)) dut (
    .clk(clk), .reset(reset), .ce(1'b1), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .convStrobe(convStrobe),
    .normalState(normalState), .cellCodeOne(c1), .cellCodeTwo(c2),
    .cellCodeThree(c3), .chargeCode(chargeCode), .tempCodeOne(t1),
    .tempCodeTwo(t2), .tempCodeThree(t3), .cellSelectOne(s1),
    .cellSelectTwo(s2), .cellSelectThree(s3),
    .tempSourceSel(tempSourceSel), .protectionsActive(protectionsActive),
    .alert(alert));
  converter_model model (.cellSelectOne(s1), .cellSelectTwo(s2),
    .cellSelectThree(s3), .tempSourceSel(tempSourceSel), .base(base),
    .charge(chg), .convStrobe(convStrobe), .cellCodeOne(c1),
    .cellCodeTwo(c2), .cellCodeThree(c3), .chargeCode(chargeCode),
    .tempCodeOne(t1), .tempCodeTwo(t2), .tempCodeThree(t3));
  // ==========
  // clock and monitor of answered reads
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (read && waitrequest === 1'b0 && expVal.size() > 0)
      check($sformatf("reg %h", expAdr.pop_front()), readdata,
            expVal.pop_front());
  end
  // ==========
  // shared tasks
  task automatic check(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [6:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin fails++; results(); end
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [31:0] e);
    expAdr.push_back(a);
    expVal.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic waitAlert(input int lim);
    n = 0;
    while (alert !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) begin fails++; results(); end
  endtask
  function automatic logic [2:0] sel(input int g);
    return g == 0 ? s1 : g == 1 ? s2 : s3;
  endfunction
  // length of the slot 1 window of group g
  task automatic win(input int g, input int e);
    n = 0;
    while (sel(g) === 3'h1 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    while (sel(g) !== 3'h1 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    t0 = cyc;
    while (sel(g) === 3'h1 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    check("window", cyc - t0, e);
  endtask
  // ==========
  // main sequence
  initial begin
    reset = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 7'h00;
    writedata = 32'h0;
    normalState = 1'b0;
    n = $urandom(32'h92ee);
    base = 14'($urandom_range(0, 14'h3000));
    chg = 16'($urandom());
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rd(`ADDR_CONTROL, 32'h0);
    rd(`ADDR_TRIM, {16'h0, `OFFSET_TRIM_DEF, 3'h0, `GAIN_TRIM_DEF});
    rd(7'h3c, 32'h0);
    bus(1'b1, 7'h3c, 32'hffffffff);
    $display("test reset done");
    normalState <= 1'b1;
    repeat (10) @(posedge clk);
    check("protect", protectionsActive, 1);
    rd(`ADDR_CONTROL, 32'h1);
    bus(1'b1, `ADDR_CONTROL, 32'h0);
    repeat (3) @(posedge clk);
    check("protect", protectionsActive, 0);
    bus(1'b1, `ADDR_CONTROL, 32'h1);
    $display("test enable done");
    repeat (3 * FRAME) @(posedge clk);
    for (int i = 0; i < 15; i++)
      rd(7'h40 + 7'(4 * i), 32'(base + 14'(64 * (i / 5) + i % 5)));
    rd(`ADDR_PACK, 32'((15 * base + 990) >> 2));
    $display("test cells done");
    bus(1'b1, `ADDR_BALANCE, 32'h0401);
    win(0, TICK);
    win(1, 4 * TICK);
    win(2, TICK);
    bus(1'b1, `ADDR_BALANCE, 32'h0);
    win(0, 4 * TICK);
    $display("test balance done");
    bus(1'b1, `ADDR_CONTROL, 32'h5);
    waitAlert(3 * FRAME);
    t0 = cyc;
    rd(`ADDR_CHARGE, {16'h0, chg});
    rd(`ADDR_STATUS, 32'h7);
    bus(1'b1, `ADDR_STATUS, 32'h1);
    repeat (2) @(posedge clk);
    check("alert", alert, 0);
    waitAlert(2 * FRAME);
    check("period", cyc - t0, FRAME);
    $display("test continuous done");
    chg <= ~chg;
    bus(1'b1, `ADDR_CONTROL, 32'h1);
    bus(1'b1, `ADDR_STATUS, 32'h1);
    bus(1'b1, `ADDR_CONTROL, 32'h9);
    rd(`ADDR_CONTROL, 32'h9);
    waitAlert(3 * FRAME);
    rd(`ADDR_CHARGE, {16'h0, chg});
    rd(`ADDR_CONTROL, 32'h1);
    bus(1'b1, `ADDR_STATUS, 32'h1);
    repeat (2 * FRAME) @(posedge clk);
    check("alert", alert, 0);
    $display("test single done");
    repeat (8 * FRAME) @(posedge clk);
    for (int i = 0; i < 3; i++)
      rd(`ADDR_TEMP1 + 7'(4 * i), 32'(base + 14'h0300 + 14'(i)));
    bus(1'b1, `ADDR_CONTROL, 32'h3);
    repeat (2) @(posedge clk);
    check("source", tempSourceSel, 1);
    repeat (17 * FRAME) @(posedge clk);
    for (int i = 0; i < 3; i++)
      rd(`ADDR_TEMP1 + 7'(4 * i), 32'(base + 14'h0200 + 14'(i)));
    $display("test temperature done");
    results();
  end
endmodule
bind battery_measurement_scheduler battery_measurement_scheduler_properties
  chk (.clk(clk), .reset(reset), .read(read), .write(write),
       .readdata(readdata), .waitrequest(waitrequest),
       .normalState(normalState), .cellSelectOne(cellSelectOne),
       .tempSourceSel(tempSourceSel),
       .protectionsActive(protectionsActive), .alert(alert));
